// File: hdl/urxa_pkg.sv
package urxa_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int DIV_W  = 16;

  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_RXDATA = 14'h0f40;
  localparam logic [13:0] IDX_STATUS = 14'h0f41;
  localparam logic [13:0] IDX_CTRL0  = 14'h0f42;
  localparam logic [13:0] IDX_CTRL1  = 14'h0f43;
  localparam logic [13:0] IDX_NODE   = 14'h0f45;
  localparam logic [13:0] IDX_BRH    = 14'h0f46;
  localparam logic [13:0] IDX_BRL    = 14'h0f47;

  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] NODE_RST  = 8'h00;
  localparam logic [7:0] BRH_RST   = 8'hff;
  localparam logic [7:0] BRL_RST   = 8'hff;

  localparam int REN_BIT    = 0;
  localparam int STAT_AVAIL = 0;
  localparam int STAT_ERR   = 1;
  localparam int STAT_MATCH = 2;

  typedef enum logic [1:0] {
    URXA_MODE_ALL,
    URXA_MODE_ADDR,
    URXA_MODE_MATCH_RUN,
    URXA_MODE_MATCH_DATA
  } urxa_mode_t;

  typedef struct packed {
    logic       valid;
    logic       ninth;
    logic [7:0] data;
  } urxa_rx_byte_t;

  typedef struct packed {
    logic mode_hi;
    logic mnode_en;
    logic mode_lo;
    logic tx_addr_bit;
    logic drv_pol;
    logic baud_ctl;
    logic data_irq_sup;
    logic ir_en;
  } urxa_ctrl1_t;

endpackage

// File: hdl/urxa_baud_gen.sv
`timescale 1ns/100ps
module urxa_baud_gen #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Reload control
  input  wire logic [DIV_W-1:0] reload,
  input  wire logic             load,
  // Counter state
  output logic      [DIV_W-1:0] count,
  output logic                  zero_tick
);
  import urxa_pkg::*;

  if (DIV_W < 2) begin : g_chk
    $error("DIV_W too small");
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count     <= '1;
      zero_tick <= 1'b0;
    end else if (load || count == '0) begin
      count     <= reload;
      zero_tick <= !load && count == '0;
    end else begin
      count     <= count - 1'b1;
      zero_tick <= 1'b0;
    end
  end

  a_reload_word: assert property (@(posedge clk) disable iff (!reset_n)
    (count == '0 && !load) |=> (zero_tick && count == $past(reload)))
    else $error("baud counter did not reload from divisor");

endmodule

// File: hdl/urxa_mnode_filter.sv
`timescale 1ns/100ps
module urxa_mnode_filter (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // Incoming byte and setup
  input  urxa_pkg::urxa_rx_byte_t     rx,
  input  wire logic                   mnode_en,
  input  urxa_pkg::urxa_mode_t        mode,
  input  wire logic [7:0]             node_addr,
  // Result
  output logic                        accept,
  output logic [7:0]                  acc_data,
  output logic                        matched
);
  import urxa_pkg::*;

  logic is_addr;
  logic hit;
  logic next_accept;

  assign is_addr = rx.ninth;
  assign hit     = rx.data == node_addr;

  always_comb begin
    next_accept = rx.valid;
    if (mnode_en) begin
      case (mode)
        URXA_MODE_ALL:        next_accept = rx.valid;
        URXA_MODE_ADDR:       next_accept = rx.valid && is_addr;
        URXA_MODE_MATCH_RUN:  next_accept = rx.valid && (is_addr ? hit : matched);
        URXA_MODE_MATCH_DATA: next_accept = rx.valid && !is_addr && matched;
        default:              next_accept = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      matched <= 1'b0;
    end else if (rx.valid && is_addr) begin
      matched <= hit;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      accept   <= 1'b0;
      acc_data <= 8'h00;
    end else begin
      accept   <= next_accept;
      acc_data <= rx.data;
    end
  end

  a_addr_mismatch: assert property (@(posedge clk) disable iff (!reset_n)
    (mnode_en && mode[1] && rx.valid && is_addr && !hit) |=> !accept)
    else $error("mismatching address byte accepted");

  a_addr_only: assert property (@(posedge clk) disable iff (!reset_n)
    (mnode_en && mode == URXA_MODE_ADDR && rx.valid && !is_addr) |=> !accept)
    else $error("data byte accepted in address-only mode");

endmodule

// File: hdl/urxa_top.sv
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
// Contract
// - Driver enable polarity follows polarity select bit
// - Receiver off: baud control gates baud interrupts
// - Receiver off, control set: interrupt at zero
// - Receiver off, control set: divisor reads live
// - Receiver on, control set: divisor reads live
// - Control clear: divisor reads return reload value
// - Suppress clear: data and errors interrupt
// - Suppress set: received data does not interrupt, receiver errors still do
// - Codec off: serial pins bypass codec
// - Codec on: all serial data through codec
// - Mode high bit: compare address bytes
// - Compare mode: interrupt and data flag after match
// - Node address register 8-bit, resets zero
// - Multinode enable bit switches filtering on
// - Mode 00 every byte, 01 address only
// - Mode 10 match run, 11 data after match
// - High and low bytes form 16-bit reload
module urxa_top (
  // Clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RESET_N,
  // APB slave
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [urxa_pkg::ADDR_W-1:0]   PADDR,
  input  wire logic [urxa_pkg::DATA_W-1:0]   PWDATA,
  output logic      [urxa_pkg::DATA_W-1:0]   PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  // Receiver framing side
  input  urxa_pkg::urxa_rx_byte_t            RX_BYTE,
  input  wire logic                          RX_ERROR,
  output logic                               UART_RXD,
  output logic                               RX_ENABLE,
  // Transmitter framing side
  input  wire logic                          TX_SHIFTING,
  input  wire logic                          TX_SERIAL,
  output logic                               TX_NINTH_BIT,
  // Infrared codec
  input  wire logic                          IR_TXD_ENC,
  input  wire logic                          IR_RXD_DEC,
  output logic                               IR_CODEC_EN,
  output logic                               IR_CODEC_TXD,
  output logic                               IR_CODEC_RXD,
  // Serial pins
  input  wire logic                          RXD_PIN,
  output logic                               TXD_PIN,
  output logic                               LINE_DRIVER_ENABLE_OUT,
  // Events and state
  output logic                               RX_IRQ,
  output logic                               RX_DATA_AVAILABLE,
  output logic                               BAUD_TICK
);
  import urxa_pkg::*;

  logic [13:0]       idx;
  logic              setup;
  logic              xfer;
  logic              wr;
  logic              rd_pop;
  logic [7:0]        rd_byte;
  logic [7:0]        ctrl0;
  urxa_ctrl1_t       ctrl1;
  logic [7:0]        node_addr;
  logic [7:0]        brh;
  logic [7:0]        brl;
  logic [7:0]        rx_data;
  logic              data_flag;
  logic              rx_err;
  logic              baud_load;
  logic [DIV_W-1:0]  baud_count;
  logic              baud_zero;
  logic              acc;
  logic [7:0]        acc_data;
  logic              matched;
  logic              ren;
  logic              rxd_s1;
  logic              rxd_s2;
  logic              next_irq;

  function automatic logic is_mapped(input logic [13:0] i);
    return i == IDX_RXDATA || i == IDX_STATUS || i == IDX_CTRL0 ||
           i == IDX_CTRL1 || i == IDX_NODE || i == IDX_BRH || i == IDX_BRL;
  endfunction

  assign idx    = PADDR[15:2];
  assign setup  = PSEL && !PENABLE;
  assign xfer   = PSEL && PENABLE && PREADY;
  assign wr     = xfer && PWRITE && is_mapped(idx);
  assign rd_pop = xfer && !PWRITE && idx == IDX_RXDATA;
  assign ren    = ctrl0[REN_BIT];

  // Read data, sampled in the setup cycle
  always_comb begin
    case (idx)
      IDX_RXDATA: rd_byte = rx_data;
      IDX_STATUS: rd_byte = {5'h00, matched, rx_err, data_flag};
      IDX_CTRL0:  rd_byte = ctrl0;
      IDX_CTRL1:  rd_byte = ctrl1;
      IDX_NODE:   rd_byte = node_addr;
      IDX_BRH:    rd_byte = ctrl1.baud_ctl ? baud_count[15:8] : brh;
      IDX_BRL:    rd_byte = ctrl1.baud_ctl ? baud_count[7:0] : brl;
      default:    rd_byte = 8'h00;
    endcase
  end

  // APB handshake: one access cycle, no wait states
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup && !is_mapped(idx);
      PRDATA  <= (setup && !PWRITE) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Control registers
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ctrl0     <= CTRL0_RST;
      ctrl1     <= CTRL1_RST;
      node_addr <= NODE_RST;
      brh       <= BRH_RST;
      brl       <= BRL_RST;
    end else if (wr) begin
      case (idx)
        IDX_CTRL0: ctrl0     <= PWDATA[7:0];
        IDX_CTRL1: ctrl1     <= PWDATA[7:0];
        IDX_NODE:  node_addr <= PWDATA[7:0];
        IDX_BRH:   brh       <= PWDATA[7:0];
        IDX_BRL:   brl       <= PWDATA[7:0];
        default:   ctrl0     <= ctrl0;
      endcase
    end
  end

  // New divisor takes effect the cycle after it is written
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      baud_load <= 1'b0;
    end else begin
      baud_load <= wr && (idx == IDX_BRH || idx == IDX_BRL);
    end
  end

  urxa_baud_gen #(
    .DIV_W (DIV_W)
  ) u_baud (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .reload    ({brh, brl}),
    .load      (baud_load),
    .count     (baud_count),
    .zero_tick (baud_zero)
  );

  // Address bytes carry the ninth bit set
  urxa_mnode_filter u_filter (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .rx        (RX_BYTE),
    .mnode_en  (ctrl1.mnode_en),
    .mode      (urxa_mode_t'({ctrl1.mode_hi, ctrl1.mode_lo})),
    .node_addr (node_addr),
    .accept    (acc),
    .acc_data  (acc_data),
    .matched   (matched)
  );

  // Received data holding and flags; a new byte wins over a pop
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rx_data   <= 8'h00;
      data_flag <= 1'b0;
    end else if (acc) begin
      rx_data   <= acc_data;
      data_flag <= 1'b1;
    end else if (rd_pop) begin
      data_flag <= 1'b0;
    end
  end

  // Error flag: write one to clear, a new error wins
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rx_err <= 1'b0;
    end else if (RX_ERROR) begin
      rx_err <= 1'b1;
    end else if (wr && idx == IDX_STATUS && PWDATA[STAT_ERR]) begin
      rx_err <= 1'b0;
    end
  end

  // Receive interrupt request
  always_comb begin
    next_irq = RX_ERROR;
    if (acc && !ctrl1.data_irq_sup) begin
      next_irq = 1'b1;
    end
    if (!ren && ctrl1.baud_ctl && baud_zero) begin
      next_irq = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      RX_IRQ            <= 1'b0;
      RX_DATA_AVAILABLE <= 1'b0;
      BAUD_TICK         <= 1'b0;
      RX_ENABLE         <= 1'b0;
      TX_NINTH_BIT      <= 1'b0;
    end else begin
      RX_IRQ            <= next_irq;
      RX_DATA_AVAILABLE <= data_flag;
      BAUD_TICK         <= baud_zero;
      RX_ENABLE         <= ren;
      TX_NINTH_BIT      <= ctrl1.tx_addr_bit;
    end
  end

  // Receive pin synchroniser
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
    end else begin
      rxd_s1 <= RXD_PIN;
      rxd_s2 <= rxd_s1;
    end
  end

  // Serial path steering; codec inputs idle high when unused
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      TXD_PIN      <= 1'b1;
      UART_RXD     <= 1'b1;
      IR_CODEC_EN  <= 1'b0;
      IR_CODEC_TXD <= 1'b1;
      IR_CODEC_RXD <= 1'b1;
    end else begin
      IR_CODEC_EN  <= ctrl1.ir_en;
      TXD_PIN      <= ctrl1.ir_en ? IR_TXD_ENC : TX_SERIAL;
      UART_RXD     <= ctrl1.ir_en ? IR_RXD_DEC : rxd_s2;
      IR_CODEC_TXD <= ctrl1.ir_en ? TX_SERIAL : 1'b1;
      IR_CODEC_RXD <= ctrl1.ir_en ? rxd_s2 : 1'b1;
    end
  end

  // Line driver enable at the selected polarity
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      LINE_DRIVER_ENABLE_OUT <= 1'b0;
    end else begin
      LINE_DRIVER_ENABLE_OUT <= TX_SHIFTING ^ ctrl1.drv_pol;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  a_de_polarity: assert property (
    ##1 (LINE_DRIVER_ENABLE_OUT == ($past(ctrl1.drv_pol) ? !$past(TX_SHIFTING)
                                                         : $past(TX_SHIFTING))))
    else $error("driver enable polarity wrong");

  a_de_whole_char: assert property (
    (TX_SHIFTING && !ctrl1.drv_pol) [*3] |=> LINE_DRIVER_ENABLE_OUT)
    else $error("driver enable dropped during character");

  a_baud_irq_on: assert property (
    (!ren && ctrl1.baud_ctl && baud_zero) |=> RX_IRQ)
    else $error("baud zero did not interrupt");

  a_baud_irq_off: assert property (
    (!ren && !ctrl1.baud_ctl && baud_zero && !acc && !RX_ERROR) |=> !RX_IRQ)
    else $error("baud interrupt while gated off");

  a_brg_read_live: assert property (
    (setup && !PWRITE && idx == IDX_BRL && ctrl1.baud_ctl)
      |=> PRDATA[7:0] == $past(baud_count[7:0]))
    else $error("divisor read not live count");

  a_brg_read_reload: assert property (
    (setup && !PWRITE && idx == IDX_BRH && !ctrl1.baud_ctl)
      |=> PRDATA[7:0] == $past(brh))
    else $error("divisor read not reload value");

  a_data_irq_on: assert property (
    (acc && !ctrl1.data_irq_sup) |=> RX_IRQ ##1 RX_DATA_AVAILABLE)
    else $error("received data did not interrupt");

  a_data_irq_off: assert property (
    (acc && ctrl1.data_irq_sup && !RX_ERROR && !(baud_zero && ctrl1.baud_ctl)) |=> !RX_IRQ)
    else $error("suppressed data still interrupted");

  a_error_irq: assert property (
    RX_ERROR |=> RX_IRQ ##0 rx_err)
    else $error("receiver error did not interrupt");

  a_ir_bypass: assert property (
    (!ctrl1.ir_en && $stable(ctrl1.ir_en)) |=> TXD_PIN == $past(TX_SERIAL))
    else $error("plain mode not bypassing codec");

  a_ir_path: assert property (
    ctrl1.ir_en |=> TXD_PIN == $past(IR_TXD_ENC) && UART_RXD == $past(IR_RXD_DEC))
    else $error("codec mode not routing through codec");

  a_node_reset: assert property (disable iff (1'b0)
    !RESET_N |=> node_addr == 8'h00 && !PREADY)
    else $error("node address not cleared by reset");

  c_baud_irq: cover property ((!ren && ctrl1.baud_ctl && baud_zero) ##1 RX_IRQ);
  c_match_accept: cover property (ctrl1.mnode_en && ctrl1.mode_hi && acc && matched);
  c_ir_mode: cover property (ctrl1.ir_en && TX_SHIFTING);
  c_unmapped: cover property (xfer && PSLVERR);

endmodule

// File: verif/urxa_remote_node.sv
`timescale 1ns/100ps
module urxa_remote_node (
  // Clock
  input  wire logic               clk,
  // Request from the bench
  input  wire logic               send,
  input  wire logic               addr_mark,
  input  wire logic [7:0]         payload,
  // Byte towards the receiver
  output urxa_pkg::urxa_rx_byte_t rx
);
  import urxa_pkg::*;

  urxa_rx_byte_t q = '0;
  logic [7:0]    last = 8'h00;

  assign rx = q;

  // Outside a byte the data lines show the inverse of the last payload and the ninth bit toggles
  always @(posedge clk) begin
    q.valid <= send;
    q.ninth <= send ? addr_mark : ~q.ninth;
    q.data  <= send ? payload : ~last;
    if (send) begin
      last <= payload;
    end
  end
endmodule

// File: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import urxa_pkg::*;

  logic          clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic          rx_error = 0, tx_shifting = 0, tx_serial = 1, ir_txd_enc = 1;
  logic          ir_rxd_dec = 1, rxd_pin = 1, send = 0, amark = 0;
  logic [15:0]   paddr = 16'h0000;
  logic [31:0]   pwdata = 32'h0, prdata, rd, rnd = 32'hb34e;
  logic [7:0]    pay = 8'h00, d, node;
  logic          pready, pslverr, uart_rxd, ir_ctx, txd, drv_en, irq, avail, tick, er, nin, mt;
  logic          ren_o, tx9, ir_en_o, ir_crx;
  urxa_rx_byte_t rx_byte;
  int            i, m, k, c, t, irq_cnt = 0, tick_cnt = 0, err_count = 0, total_checks = 0;

  urxa_remote_node node_u (.clk(clk), .send(send), .addr_mark(amark), .payload(pay),
                           .rx(rx_byte));

  urxa_top dut_u (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RX_BYTE(rx_byte), .RX_ERROR(rx_error), .UART_RXD(uart_rxd),
    .RX_ENABLE(ren_o), .TX_SHIFTING(tx_shifting), .TX_SERIAL(tx_serial), .TX_NINTH_BIT(tx9),
    .IR_TXD_ENC(ir_txd_enc), .IR_RXD_DEC(ir_rxd_dec), .IR_CODEC_EN(ir_en_o),
    .IR_CODEC_TXD(ir_ctx), .IR_CODEC_RXD(ir_crx), .RXD_PIN(rxd_pin), .TXD_PIN(txd),
    .LINE_DRIVER_ENABLE_OUT(drv_en), .RX_IRQ(irq), .RX_DATA_AVAILABLE(avail),
    .BAUD_TICK(tick));

  always #50 clk = ~clk;

  always @(posedge clk) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (tick === 1'b1) tick_cnt <= tick_cnt + 1;
  end

  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task conclude;
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task run(input int n);
    repeat (n) @(posedge clk);
  endtask

  task apb(input logic w, input logic [13:0] idx, input logic [7:0] wd);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {rnd[31:8], wd};
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    if (n >= 16) begin
      err_count++;
      conclude;
    end
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask

  task wr(input logic [13:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v);
  endtask

  task rdc(input logic [13:0] idx, input logic [7:0] v);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, v});
  endtask

  // One byte from the remote node; ex says whether the filter should keep it
  task rcv(input logic n9, input logic [7:0] v, input logic ex, input logic sup);
    c = irq_cnt;
    send <= 1;
    amark <= n9;
    pay <= v;
    @(posedge clk);
    send <= 0;
    run(8);
    chk(32'(irq_cnt - c), 32'(ex && !sup));
    chk(32'(avail), 32'(ex));
    if (ex) begin
      rdc(IDX_RXDATA, v);
      run(2);
    end
  endtask

  task errp;
    c = irq_cnt;
    rx_error <= 1;
    @(posedge clk);
    rx_error <= 0;
    run(4);
    chk(32'(irq_cnt - c), 32'd1);
    wr(IDX_STATUS, 8'h02);
  endtask

  initial begin
    run(6);
    reset_n <= 1;
    @(posedge clk);
    rdc(IDX_NODE, NODE_RST);
    rdc(IDX_BRH, BRH_RST);
    apb(1'b0, 14'h0f44, 8'h00);
    chk(32'(er), 32'd1);
    rnd = lfsr(rnd);
    node = rnd[7:0];
    wr(IDX_NODE, node);
    rdc(IDX_NODE, node);
    for (i = 0; i < 4; i++) begin
      wr(IDX_CTRL1, {3'h0, i[0], i[1], 3'h0});
      tx_shifting <= i[0];
      run(3);
      chk(32'(drv_en), 32'(i[0] ^ i[1]));
      chk(32'(tx9), 32'(i[0]));
    end
    for (i = 0; i < 2; i++) begin
      wr(IDX_CTRL1, {7'h0, i[0]});
      rnd = lfsr(rnd);
      tx_serial <= rnd[0];
      ir_txd_enc <= rnd[1];
      rxd_pin <= rnd[2];
      ir_rxd_dec <= rnd[3];
      run(5);
      chk(32'(txd), 32'(i[0] ? rnd[1] : rnd[0]));
      chk(32'(uart_rxd), 32'(i[0] ? rnd[3] : rnd[2]));
      chk(32'(ir_ctx), 32'(i[0] ? rnd[0] : 1'b1));
      chk(32'(ir_crx), 32'(i[0] ? rnd[2] : 1'b1));
      chk(32'(ir_en_o), 32'(i[0]));
    end
    // Reload 0x1000: the live count sits at 0x0fxx for 256 cycles
    wr(IDX_BRH, 8'h10);
    wr(IDX_BRL, 8'h00);
    for (i = 0; i < 2; i++) begin
      wr(IDX_CTRL0, {7'h0, i[0]});
      wr(IDX_CTRL1, 8'h04);
      rdc(IDX_BRH, 8'h0f);
      wr(IDX_CTRL1, 8'h00);
      rdc(IDX_BRH, 8'h10);
      rdc(IDX_BRL, 8'h00);
    end
    wr(IDX_CTRL0, 8'h00);
    wr(IDX_BRH, 8'h00);
    wr(IDX_BRL, 8'h07);
    for (i = 0; i < 2; i++) begin
      wr(IDX_CTRL1, {5'h0, i[0], 2'h0});
      run(10);
      c = irq_cnt;
      t = tick_cnt;
      run(80);
      chk(32'(irq_cnt - c), i[0] ? 32'd10 : 32'd0);
      chk(32'(tick_cnt - t), 32'd10);
    end
    wr(IDX_CTRL0, 8'h01);
    run(2);
    chk(32'(ren_o), 32'd1);
    for (i = 0; i < 2; i++) begin
      wr(IDX_CTRL1, {6'h0, i[0], 1'b0});
      rnd = lfsr(rnd);
      rcv(1'b0, rnd[7:0], 1'b1, i[0]);
      errp();
    end
    mt = 0;
    for (m = 0; m < 5; m++) begin
      wr(IDX_CTRL1, (m == 4) ? 8'h00 : {m[1], 1'b1, m[0], 5'h0});
      for (k = 0; k < 4; k++) begin
        rnd = lfsr(rnd);
        nin = ~k[0];
        d = (k == 0) ? node : (k == 2) ? (node ^ 8'h5a) : rnd[7:0];
        if (nin) mt = (d == node);
        rcv(nin, d, (m == 4 || m == 0) ? 1'b1 : (m == 1) ? nin :
            (m == 2) ? mt : (!nin && mt), 1'b0);
      end
    end
    conclude;
  end
endmodule
